// file: ued_dma_term.sv
// ued_dma_term: dma request, strobe and end-of-transfer logic for one endpoint
// assumes all pins are synchronous to I_SYS_CLK and active high;
// endpoint buffer logic sits outside and obeys the discard/validate pulses
//
// Overview of operation
// - mode bit selects ack-only or separate-strobe mode
// - ack-only: acknowledge strobes data, strobes ignored
// - request out; acknowledge confirms; end input terminates
// - bulk ends: input, count, short packet, disable
// - external end on OUT discards active buffer
// - double-buffered OUT: inactive buffer stays intact
// - external end on IN validates packet for sending
// - sixteen-bit writable byte count register
// - enable rising loads counter from byte count
// - count end enabled: halt after programmed bytes
// - short OUT packet ends after its bytes moved
// - short packet sets length, no count needed
// - IN short mode: counter zero ends transfer
// - clearing enable stops dma without event
// - iso ends: input, count, end-of-packet, disable
// - 4-bit index picks endpoint; its direction bit sets direction
// - acknowledge always selects the dma endpoint
// - one dma endpoint; programmed I/O interleaves
`timescale 1ns/1ps
`default_nettype none
module ued_dma_term
  import ued_pkg::*;
#(
  parameter int unsigned CNT_W = UED_CNT_W,
  parameter int unsigned NUM_EP = UED_NUM_EP
) (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_SYS_RST,
  // configuration bits
  input wire logic I_ACK_ONLY_SELECT,
  input wire logic I_TRANSFER_ENABLE_BIT,
  input wire logic I_COUNT_END_ENABLE,
  input wire logic I_SHORT_PACKET_END_ENABLE,
  input wire logic [UED_EP_W-1:0] I_DMA_ENDPOINT_INDEX,
  input wire logic [NUM_EP-1:0] I_ENDPOINT_DIRECTION,
  input wire logic [NUM_EP-1:0] I_ENDPOINT_ISO,
  // byte count register write port
  input wire logic I_CNT_WR,
  input wire logic [CNT_W-1:0] I_CNT_DATA,
  // dma controller pins
  input wire logic I_TRANSFER_ACKNOWLEDGE,
  input wire logic I_TRANSFER_END_INPUT,
  input wire logic I_READ_STROBE,
  input wire logic I_WRITE_STROBE,
  output logic O_TRANSFER_REQUEST,
  // endpoint buffer side
  input wire logic I_BUF_READY,
  input wire logic I_SHORT_PKT_LAST,
  input wire logic I_USB_EOP,
  input wire logic [UED_EP_W-1:0] I_PIO_EP,
  output logic [UED_EP_W-1:0] O_BUF_EP,
  output logic O_XFER_STROBE,
  output logic O_XFER_WRITE,
  output logic O_DISCARD_ACTIVE,
  output logic O_VALIDATE_IN,
  // status
  output logic O_ACTIVE,
  output logic O_EOT_EVENT,
  output logic [2:0] O_EOT_CAUSE,
  output logic [CNT_W-1:0] O_BYTE_COUNT,
  output logic [CNT_W-1:0] O_REMAIN
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic ep_bit(input logic [NUM_EP-1:0] v,
                                  input logic [UED_EP_W-1:0] ep);
    ep_bit = v[ep];
  endfunction : ep_bit

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  ued_state_t state_q;
  ued_state_t state_d;
  logic [CNT_W-1:0] byte_count_q;
  logic en_prev_q;
  logic ack_prev_q;
  logic rd_prev_q;
  logic wr_prev_q;
  logic dir_write;
  logic is_iso;
  logic en_rise;
  logic run;
  logic strobe;
  logic cnt_zero;
  logic cnt_last;
  logic reach_zero;
  logic end_ext;
  logic end_count;
  logic end_short;
  logic end_eop;
  logic end_any;
  ued_cause_t cause_d;

  ////////////////////////////////////////////////////////////////////////////
  // endpoint selection and direction

  assign dir_write = ep_bit(I_ENDPOINT_DIRECTION, I_DMA_ENDPOINT_INDEX);
  assign is_iso = ep_bit(I_ENDPOINT_ISO, I_DMA_ENDPOINT_INDEX);
  // acknowledge steers buffer access to the dma endpoint, else pio endpoint
  assign O_BUF_EP = I_TRANSFER_ACKNOWLEDGE ? I_DMA_ENDPOINT_INDEX : I_PIO_EP;
  assign O_XFER_WRITE = dir_write;

  ////////////////////////////////////////////////////////////////////////////
  // byte count register

  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      byte_count_q <= CNT_W'(UED_CNT_RST);
    end else if (I_CNT_WR) begin
      byte_count_q <= I_CNT_DATA;
    end
  end

  assign O_BYTE_COUNT = byte_count_q;

  ////////////////////////////////////////////////////////////////////////////
  // pin history for edge detection

  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      en_prev_q <= 1'b0;
      ack_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end else begin
      en_prev_q <= I_TRANSFER_ENABLE_BIT;
      ack_prev_q <= I_TRANSFER_ACKNOWLEDGE;
      rd_prev_q <= I_READ_STROBE;
      wr_prev_q <= I_WRITE_STROBE;
    end
  end

  assign en_rise = I_TRANSFER_ENABLE_BIT && !en_prev_q;
  assign run = (state_q == UED_ST_RUN) && I_TRANSFER_ENABLE_BIT;

  // data strobe: ack edge alone, or direction strobe edge qualified by ack
  always_comb begin
    if (I_ACK_ONLY_SELECT) begin
      strobe = I_TRANSFER_ACKNOWLEDGE && !ack_prev_q;
    end else if (dir_write) begin
      strobe = I_TRANSFER_ACKNOWLEDGE && I_WRITE_STROBE && !wr_prev_q;
    end else begin
      strobe = I_TRANSFER_ACKNOWLEDGE && I_READ_STROBE && !rd_prev_q;
    end
  end

  assign O_XFER_STROBE = run && strobe;

  ////////////////////////////////////////////////////////////////////////////
  // transfer counter

  ued_xfer_counter #(
    .W(CNT_W)
  ) u_counter (
    .i_clk(I_SYS_CLK),
    .i_rst(I_SYS_RST),
    .i_load(en_rise),
    .i_load_val(byte_count_q),
    .i_dec(O_XFER_STROBE),
    .o_count(O_REMAIN),
    .o_zero(cnt_zero),
    .o_last(cnt_last)
  );

  assign reach_zero = cnt_zero || (O_XFER_STROBE && cnt_last);

  ////////////////////////////////////////////////////////////////////////////
  // end-of-transfer sources

  assign end_ext = run && I_TRANSFER_END_INPUT;
  assign end_count = run && I_COUNT_END_ENABLE && reach_zero;
  // short packet applies to bulk only; eop applies to iso only
  assign end_short = run && !is_iso && I_SHORT_PACKET_END_ENABLE && (dir_write ?
                     reach_zero : (O_XFER_STROBE && I_SHORT_PKT_LAST));
  assign end_eop = run && is_iso && I_USB_EOP;
  assign end_any = end_ext || end_count || end_short || end_eop;

  always_comb begin
    if (end_ext) begin
      cause_d = UED_END_EXT;
    end else if (end_count) begin
      cause_d = UED_END_COUNT;
    end else if (end_short) begin
      cause_d = UED_END_SHORT;
    end else begin
      cause_d = UED_END_EOP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state machine

  always_comb begin
    state_d = state_q;
    case (state_q)
      UED_ST_IDLE: begin
        if (en_rise) begin
          state_d = UED_ST_RUN;
        end
      end
      UED_ST_RUN: begin
        if (!I_TRANSFER_ENABLE_BIT) begin
          state_d = UED_ST_IDLE;
        end else if (end_any) begin
          state_d = UED_ST_HALT;
        end
      end
      UED_ST_HALT: begin
        if (!I_TRANSFER_ENABLE_BIT) begin
          state_d = UED_ST_IDLE;
        end
      end
      default: begin
        state_d = UED_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      state_q <= UED_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status and buffer action pulses

  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_EOT_EVENT <= 1'b0;
      O_EOT_CAUSE <= UED_END_NONE;
      O_DISCARD_ACTIVE <= 1'b0;
      O_VALIDATE_IN <= 1'b0;
    end else begin
      O_EOT_EVENT <= end_any;
      O_DISCARD_ACTIVE <= end_ext && !dir_write;
      O_VALIDATE_IN <= end_ext && dir_write;
      if (end_any) begin
        O_EOT_CAUSE <= cause_d;
      end else if ((state_q != UED_ST_IDLE) && !I_TRANSFER_ENABLE_BIT) begin
        O_EOT_CAUSE <= UED_END_DISABLE;
      end else if (en_rise) begin
        O_EOT_CAUSE <= UED_END_NONE;
      end
    end
  end

  assign O_ACTIVE = (state_q == UED_ST_RUN);
  assign O_TRANSFER_REQUEST = run && I_BUF_READY && !end_any;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_ext_end;
    run && I_TRANSFER_END_INPUT;
  endsequence

  sequence s_halted;
    (state_q == UED_ST_HALT) && O_EOT_EVENT;
  endsequence

  req_after_end_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    s_ext_end ##1 I_TRANSFER_ENABLE_BIT |-> !O_TRANSFER_REQUEST)
    else $error("request raised after end of transfer");

  ext_end_halt_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    s_ext_end |=> s_halted)
    else $error("external end did not halt");

  out_discard_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    (s_ext_end and (!dir_write)) |=> O_DISCARD_ACTIVE && !O_VALIDATE_IN)
    else $error("OUT external end did not discard");

  in_validate_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    (s_ext_end and dir_write) |=> O_VALIDATE_IN && !O_DISCARD_ACTIVE)
    else $error("IN external end did not validate");

  ack_only_strobe_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    run && I_ACK_ONLY_SELECT && $rose(I_TRANSFER_ACKNOWLEDGE) |-> O_XFER_STROBE)
    else $error("ack edge did not strobe in ack-only mode");

  compat_needs_rw_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    O_XFER_STROBE && !I_ACK_ONLY_SELECT |-> (I_READ_STROBE || I_WRITE_STROBE))
    else $error("compatible mode strobe without read or write");

  count_load_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    en_rise |=> O_REMAIN == $past(byte_count_q))
    else $error("counter not loaded on enable");

  count_end_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    run && I_COUNT_END_ENABLE && O_XFER_STROBE && cnt_last && !I_TRANSFER_END_INPUT |=>
      O_EOT_EVENT && O_EOT_CAUSE == UED_END_COUNT && O_REMAIN == CNT_W'(UED_CNT_RST))
    else $error("count end not raised at last byte");

  disable_quiet_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    O_ACTIVE && !I_TRANSFER_ENABLE_BIT && !end_any |=>
      !O_EOT_EVENT && state_q == UED_ST_IDLE && !O_TRANSFER_REQUEST)
    else $error("disable raised an event or left dma running");

  ack_select_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    I_TRANSFER_ACKNOWLEDGE |-> O_BUF_EP == I_DMA_ENDPOINT_INDEX)
    else $error("acknowledge did not select dma endpoint");

endmodule : ued_dma_term
`default_nettype wire

// file: ued_pkg.sv
// ued_pkg: shared constants and types for the endpoint dma termination block
// assumes a single system clock domain; no timing constants are needed
package ued_pkg;

  localparam int unsigned UED_CNT_W = 16;
  localparam int unsigned UED_EP_W = 4;
  localparam int unsigned UED_NUM_EP = 16;

  localparam logic [15:0] UED_CNT_RST = 16'h0000;
  localparam logic [15:0] UED_CNT_ONE = 16'h0001;
  localparam logic [3:0] UED_EP_RST = 4'h0;

  typedef enum logic [1:0] {
    UED_ST_IDLE = 2'b00,
    UED_ST_RUN = 2'b01,
    UED_ST_HALT = 2'b10
  } ued_state_t;

  typedef enum logic [2:0] {
    UED_END_NONE = 3'b000,
    UED_END_EXT = 3'b001,
    UED_END_COUNT = 3'b010,
    UED_END_SHORT = 3'b011,
    UED_END_EOP = 3'b100,
    UED_END_DISABLE = 3'b101
  } ued_cause_t;

endpackage : ued_pkg

// file: ued_xfer_counter.sv
// ued_xfer_counter: loadable down counter of bytes left in a transfer
// assumes load and decrement come from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module ued_xfer_counter
  import ued_pkg::*;
#(
  parameter int unsigned W = UED_CNT_W
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // control
  input wire logic i_load,
  input wire logic [W-1:0] i_load_val,
  input wire logic i_dec,
  // state
  output logic [W-1:0] o_count,
  output logic o_zero,
  output logic o_last
);

  logic [W-1:0] count_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count_q <= W'(UED_CNT_RST);
    end else if (i_load) begin
      count_q <= i_load_val;
    end else if (i_dec && (count_q != W'(UED_CNT_RST))) begin
      count_q <= count_q - W'(UED_CNT_ONE);
    end
  end

  assign o_count = count_q;
  assign o_zero = (count_q == W'(UED_CNT_RST));
  assign o_last = (count_q == W'(UED_CNT_ONE));

endmodule : ued_xfer_counter
`default_nettype wire

// file: ued_dma_host_model.sv
// ued_dma_host_model: behavioural dma controller on the far side of the request pin
// assumes it shares the device clock; acks one byte per request, then strobes rd or wr
`timescale 1ns/1ps
`default_nettype none
module ued_dma_host_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // device side
  input wire logic i_req,
  input wire logic i_write,
  input wire logic i_slow,
  output logic o_ack,
  output logic o_rd,
  output logic o_wr
);
  logic [1:0] ph_q;
  logic slow_q;
  ////////////////////////////////////////////////////////////////////////////
  // ack, then rd/wr pulse under ack, then release; slow answers every other look
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ph_q <= 2'h0;
      slow_q <= 1'h0;
      o_ack <= 1'h0;
      o_rd <= 1'h0;
      o_wr <= 1'h0;
    end else begin
      slow_q <= ~slow_q;
      case (ph_q)
        2'h0: if (i_req && (!i_slow || slow_q)) begin
          ph_q <= 2'h1;
          o_ack <= 1'h1;
        end
        2'h1: begin
          ph_q <= 2'h2;
          o_rd <= !i_write;
          o_wr <= i_write;
        end
        default: begin
          ph_q <= 2'h0;
          o_ack <= 1'h0;
          o_rd <= 1'h0;
          o_wr <= 1'h0;
        end
      endcase
    end
  end
endmodule : ued_dma_host_model
`default_nettype wire

// file: ued_dma_term_test.sv
// ued_dma_term_test: self-checking bench for the dma termination block
// assumes ued_dma_host_model answers requests; one table row per transfer
`timescale 1ns/1ps
`default_nettype none
module ued_dma_term_test;
  typedef struct {
    logic dir, iso, cen, sen;
    logic [15:0] cnt;
    int stop, nstop, stb;
    logic [2:0] cause;
  } ued_row_t;
  // stop: 1 end input, 2 short packet, 3 end of packet, 4 disable
  ued_row_t rows[10] = '{
    '{1'h0, 1'h0, 1'h1, 1'h0, 16'h0003, 0, 0, 3, 3'h2},
    '{1'h1, 1'h0, 1'h1, 1'h0, 16'h0005, 0, 0, 5, 3'h2},
    '{1'h0, 1'h0, 1'h0, 1'h0, 16'h0008, 1, 2, 2, 3'h1},
    '{1'h1, 1'h0, 1'h0, 1'h0, 16'h0008, 1, 2, 2, 3'h1},
    '{1'h0, 1'h0, 1'h0, 1'h1, 16'h000A, 2, 0, 3, 3'h3},
    '{1'h1, 1'h0, 1'h0, 1'h1, 16'h0004, 0, 0, 4, 3'h3},
    '{1'h0, 1'h1, 1'h0, 1'h0, 16'h0009, 3, 2, 2, 3'h4},
    '{1'h1, 1'h1, 1'h1, 1'h0, 16'h0002, 0, 0, 2, 3'h2},
    '{1'h0, 1'h0, 1'h0, 1'h0, 16'h0006, 4, 2, 2, 3'h5},
    '{1'h1, 1'h0, 1'h1, 1'h0, 16'h0000, 0, 0, 0, 3'h2}};
  ued_row_t r;
  logic clk = 0, rst = 1, mode = 0, en = 0, cen = 0, sen = 0, cwr = 0;
  logic eop = 0, xend = 0, sarm = 0, slow = 0, shortl = 0, rdy = 1;
  logic [3:0] idx = 4'h2;
  logic [15:0] dir = 16'h0, iso = 16'h0, cdat = 16'h0;
  logic ack, rd, wr, req, stb, xw, disc, val, act, ev;
  logic [3:0] bep;
  logic [2:0] cause;
  logic [15:0] bcnt, rem;
  int mismatches = 0, samples_checked = 0, nstb = 0, ndisc = 0, nval = 0, nev = 0;
  int cyc = 0, slast = 0;
  ued_dma_term uut (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_ACK_ONLY_SELECT(mode),
    .I_TRANSFER_ENABLE_BIT(en), .I_COUNT_END_ENABLE(cen), .I_SHORT_PACKET_END_ENABLE(sen),
    .I_DMA_ENDPOINT_INDEX(idx), .I_ENDPOINT_DIRECTION(dir), .I_ENDPOINT_ISO(iso),
    .I_CNT_WR(cwr), .I_CNT_DATA(cdat), .I_TRANSFER_ACKNOWLEDGE(ack),
    .I_TRANSFER_END_INPUT(xend), .I_READ_STROBE(rd), .I_WRITE_STROBE(wr),
    .O_TRANSFER_REQUEST(req), .I_BUF_READY(rdy), .I_SHORT_PKT_LAST(shortl),
    .I_USB_EOP(eop), .I_PIO_EP(4'h1), .O_BUF_EP(bep), .O_XFER_STROBE(stb),
    .O_XFER_WRITE(xw), .O_DISCARD_ACTIVE(disc), .O_VALIDATE_IN(val), .O_ACTIVE(act),
    .O_EOT_EVENT(ev), .O_EOT_CAUSE(cause), .O_BYTE_COUNT(bcnt), .O_REMAIN(rem));
  ued_dma_host_model host (.i_clk(clk), .i_rst(rst), .i_req(req), .i_write(xw),
    .i_slow(slow), .o_ack(ack), .o_rd(rd), .o_wr(wr));
  ////////////////////////////////////////////////////////////////////////////
  always #25 clk = ~clk;
  task automatic chk16(input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk16
  task automatic chk1(input logic e, input logic g);
    chk16(16'(e), 16'(g));
  endtask : chk1
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic summarize();
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    nstb += int'(stb);
    ndisc += int'(disc);
    nval += int'(val);
    nev += int'(ev);
    if (ack === 1'h1) chk16(16'(idx), 16'(bep));
    else chk16(16'h1, 16'(bep));
  end
  always @(posedge clk) begin
    #1;
    shortl = sarm && (nstb == slast);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    step(10);
    rst = 0;
    for (int i = 0; i < 10; i++) begin
      r = rows[i];
      mode = i[0];
      slow = i[1];
      idx = 4'h2 + 4'(i);
      dir[idx] = r.dir;
      iso[idx] = r.iso;
      cen = r.cen;
      sen = r.sen;
      cdat = r.cnt;
      cwr = 1;
      step(1);
      cwr = 0;
      chk16(r.cnt, bcnt);
      nstb = 0;
      ndisc = 0;
      nval = 0;
      nev = 0;
      sarm = (r.stop == 2);
      slast = r.stb - 1;
      en = 1;
      step(1);
      chk1(1'(r.stb != 0), req);
      chk16(r.cnt, rem);
      for (int k = 0; k < 200; k++) begin
        if (r.nstop != 0 ? nstb == r.nstop : (k > 2 && act !== 1'h1)) break;
        step(1);
      end
      case (r.stop)
        1: xend = 1;
        3: eop = 1;
        4: en = 0;
        default: ;
      endcase
      step(1);
      xend = 0;
      eop = 0;
      step(3);
      chk16(16'(r.cause), 16'(cause));
      chk16(r.cnt - 16'(r.stb), rem);
      chk16(16'(r.stb), 16'(nstb));
      chk16(16'(r.cause != 3'h5), 16'(nev));
      chk16(16'(r.cause == 3'h1 && !r.dir), 16'(ndisc));
      chk16(16'(r.cause == 3'h1 && r.dir), 16'(nval));
      chk1(1'h0, req);
      chk1(r.dir, xw);
      en = 0;
      sarm = 0;
      step(2);
    end
    cdat = 16'h00FF;
    cwr = 1;
    step(1);
    cwr = 0;
    en = 1;
    step(4);
    chk1(1'h1, act);
    rdy = 0;
    step(1);
    chk1(1'h0, req);
    rdy = 1;
    step(1);
    chk1(1'h1, req);
    rst = 1;
    step(1);
    chk1(1'h0, req);
    chk16(16'h0000, rem);
    chk16(16'h0000, bcnt);
    en = 0;
    step(1);
    rst = 0;
    step(2);
    chk1(1'h0, act);
    summarize();
  end
endmodule : ued_dma_term_test
`default_nettype wire
